// ==== core/tcm_pkg.sv ====
/*
 Package for the test clock mode select block: register map, strap bit
 positions, select codes and carrier structs.
 Assumes one clock domain at 250 MHz and an AXI4-Lite register master.
*/
package tcm_pkg;
    localparam int unsigned TCM_AW = 4;
    localparam int unsigned TCM_DW = 32;
    // Register byte offsets
    localparam logic [TCM_AW-1:0] TCM_OFS_CTRL = 4'h0;
    localparam logic [TCM_AW-1:0] TCM_OFS_STAT = 4'h4;
    localparam logic [TCM_AW-1:0] TCM_OFS_SEL = 4'h8;
    // Control fields
    localparam int unsigned TCM_CTRL_CKEN = 0;
    localparam logic [TCM_DW-1:0] TCM_CTRL_RST = 32'h0000_0001;
    // Strap bit positions on the shared bus pins
    localparam int unsigned TCM_AD_BYPASS = 9;
    localparam int unsigned TCM_AD_RSTEN = 29;
    localparam int unsigned TCM_AD_SYS_LO = 5;
    localparam int unsigned TCM_AD_GP_LO = 12;
    localparam int unsigned TCM_CBE_RATIO = 1;
    // Clock source select codes
    localparam logic [2:0] TCM_SEL_DIV2 = 3'h0;
    localparam logic [2:0] TCM_SEL_RAW = 3'h1;
    localparam logic [2:0] TCM_SEL_PLL = 3'h4;
    // AXI responses
    localparam logic [1:0] TCM_RESP_OKAY = 2'h0;
    localparam logic [1:0] TCM_RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        TCM_NORMAL = 3'b001,
        TCM_BYPASS = 3'b010,
        TCM_CLKOUT = 3'b100
    } tcm_mode_e;

    typedef struct packed {
        logic [31:0] ad;
        logic [3:0] cbe_n;
        logic par;
        logic irdy_n;
    } tcm_straps_s;

    typedef struct packed {
        logic sys_clock_in;
        logic graphics_port_clock_in;
        logic sys_pll_1x;
    } tcm_clocks_s;

    typedef struct packed {
        logic [2:0] sys_sel;
        logic [2:0] gp_sel;
        logic ratio_4x;
        logic rst_en;
    } tcm_latch_s;
endpackage : tcm_pkg

// ==== core/tcm_clock_mux.sv ====
/*
 Clock source selector for one observed clock domain: divide-by-two,
 raw input, or system PLL 1x output, registered.
 Assumes the sources are sampled as synchronous levels.
*/
`timescale 1ns/1ps
module tcm_clock_mux (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic sync_rst,
    input wire logic [2:0] sel,
    input wire logic raw_in,
    input wire logic pll_in,
    output logic div_out,
    output logic clk_out
);
    import tcm_pkg::*;

    logic raw_q_r;
    logic div_r;
    logic out_r;

    // Divide-by-two on rising edges of the raw clock
    always_ff @(posedge aclk)
    begin
        if (!aresetn || sync_rst)
        begin
            raw_q_r <= 1'b0;
            div_r <= 1'b0;
        end
        else if (ce)
        begin
            raw_q_r <= raw_in;
            if (raw_in && !raw_q_r)
                div_r <= ~div_r;
        end
    end

    // Source select; reserved codes drive low
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            out_r <= 1'b0;
        else if (ce)
        begin
            unique case (sel)
                TCM_SEL_DIV2: out_r <= div_r;
                TCM_SEL_RAW: out_r <= raw_in;
                TCM_SEL_PLL: out_r <= pll_in;
                default: out_r <= 1'b0;
            endcase
        end
    end

    assign div_out = div_r;
    assign clk_out = out_r;
endmodule : tcm_clock_mux

// ==== core/tcm_test_clock.sv ====
/*
 Test clock mode select: strap decode at test entry, PLL bypass clocking,
 clock output onto grant pins, and an AXI4-Lite status/control port.
 Assumes straps and clocks are synchronous to aclk and held stable at entry.
*/
`timescale 1ns/1ps
// What this block does
// - Test pin low with AD9 high enters bypass; core clocked from external clocks.
// - Bypass with ratio strap 0: 2x clocks divided by two feed core.
// - Bypass with ratio strap 1: 2x system, 4x graphics clock accepted.
// - In bypass, IRDY low gives synchronous clocking reset if enabled.
// - AD29 low at bypass entry enables the clocking reset.
// - Test pin low with AD9 low and PAR low enters clock output mode, PLLs running.
// - Clock output mode drives system clock on grant 5, graphics on 6.
// - AD7:5 selects system output: divided, raw, or PLL 1x; others reserved.
// - AD14:12 selects graphics output: divided, raw, or PLL 1x.
module tcm_test_clock (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic test_n,
    input wire tcm_pkg::tcm_straps_s straps,
    input wire tcm_pkg::tcm_clocks_s clocks,
    input wire logic [6:5] bus_gnt_n,
    output logic [6:5] gnt_n_out,
    output logic core_clk_en,
    output logic gp_core_clk_en,
    output logic clk_logic_rst,
    output tcm_pkg::tcm_mode_e mode_out,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import tcm_pkg::*;

    tcm_mode_e mode_r;
    tcm_mode_e mode_nxt;
    tcm_latch_s latch_r;
    logic test_q_r;
    logic sync_rst;
    logic sys_div;
    logic gp_div;
    logic sys_obs;
    logic gp_obs;
    logic gp_q_r;
    logic [6:5] gnt_r;
    logic core_en_r;
    logic gp_en_r;
    logic crst_r;
    logic [31:0] ctrl_r;
    logic aw_hold_r;
    logic w_hold_r;
    logic [3:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic rvalid_r;
    logic [1:0] rresp_r;
    logic [31:0] rdata_r;

    // Mode decode at the falling edge of the test pin
    always_comb
    begin
        mode_nxt = mode_r;
        if (test_n)
            mode_nxt = TCM_NORMAL;
        else if (test_q_r)
        begin
            if (straps.ad[TCM_AD_BYPASS])
                mode_nxt = TCM_BYPASS;
            else if (!straps.par)
                mode_nxt = TCM_CLKOUT;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            mode_r <= TCM_NORMAL;
            test_q_r <= 1'b1;
        end
        else if (ce)
        begin
            mode_r <= mode_nxt;
            test_q_r <= test_n;
        end
    end

    // Strap capture at entry only
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            latch_r <= '0;
        else if (ce && !test_n && test_q_r)
        begin
            latch_r.sys_sel <= straps.ad[TCM_AD_SYS_LO +: 3];
            latch_r.gp_sel <= straps.ad[TCM_AD_GP_LO +: 3];
            latch_r.ratio_4x <= straps.cbe_n[TCM_CBE_RATIO];
            latch_r.rst_en <= ~straps.ad[TCM_AD_RSTEN];
        end
    end

    // Clocking reset from IRDY low, only if enabled at entry
    assign sync_rst = (mode_r == TCM_BYPASS) && latch_r.rst_en && !straps.irdy_n;

    tcm_clock_mux u_sys (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .sync_rst(sync_rst),
        .sel(latch_r.sys_sel),
        .raw_in(clocks.sys_clock_in),
        .pll_in(clocks.sys_pll_1x),
        .div_out(sys_div),
        .clk_out(sys_obs)
    );

    tcm_clock_mux u_gp (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .sync_rst(sync_rst),
        .sel(latch_r.gp_sel),
        .raw_in(clocks.graphics_port_clock_in),
        .pll_in(clocks.sys_pll_1x),
        .div_out(gp_div),
        .clk_out(gp_obs)
    );

    // Core clock enables: divided 1x, or one pulse per rising edge of the 4x graphics clock
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            core_en_r <= 1'b1;
            gp_en_r <= 1'b1;
            crst_r <= 1'b0;
            gp_q_r <= 1'b0;
        end
        else if (ce)
        begin
            crst_r <= sync_rst;
            gp_q_r <= clocks.graphics_port_clock_in;
            if (mode_r == TCM_BYPASS && ctrl_r[TCM_CTRL_CKEN])
            begin
                core_en_r <= sys_div;
                if (latch_r.ratio_4x)
                    gp_en_r <= clocks.graphics_port_clock_in && !gp_q_r;
                else
                    gp_en_r <= gp_div;
            end
            else
            begin
                core_en_r <= 1'b1;
                gp_en_r <= 1'b1;
            end
        end
    end

    // Grant pins: observed clocks in output mode, else bus grants
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            gnt_r <= 2'b11;
        else if (ce)
        begin
            if (mode_r == TCM_CLKOUT)
                gnt_r <= {gp_obs, sys_obs};
            else
                gnt_r <= bus_gnt_n;
        end
    end

    assign gnt_n_out = gnt_r;
    assign core_clk_en = core_en_r;
    assign gp_core_clk_en = gp_en_r;
    assign clk_logic_rst = crst_r;
    assign mode_out = mode_r;

    // AXI4-Lite write path
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            awaddr_r <= '0;
            wdata_r <= '0;
            wstrb_r <= '0;
            bvalid_r <= 1'b0;
            bresp_r <= TCM_RESP_OKAY;
            ctrl_r <= TCM_CTRL_RST;
        end
        else if (ce)
        begin
            if (s_axi_awvalid && !aw_hold_r && !bvalid_r)
            begin
                aw_hold_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_hold_r && !bvalid_r)
            begin
                w_hold_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            if (aw_hold_r && w_hold_r)
            begin
                aw_hold_r <= 1'b0;
                w_hold_r <= 1'b0;
                bvalid_r <= 1'b1;
                if (awaddr_r == TCM_OFS_CTRL)
                begin
                    bresp_r <= TCM_RESP_OKAY;
                    if (wstrb_r[0])
                        ctrl_r[TCM_CTRL_CKEN] <= wdata_r[TCM_CTRL_CKEN];
                end
                else if (awaddr_r == TCM_OFS_STAT || awaddr_r == TCM_OFS_SEL)
                    bresp_r <= TCM_RESP_OKAY;
                else
                    bresp_r <= TCM_RESP_SLVERR;
            end
            else if (bvalid_r && s_axi_bready)
                bvalid_r <= 1'b0;
        end
    end

    assign s_axi_awready = !aw_hold_r && !bvalid_r;
    assign s_axi_wready = !w_hold_r && !bvalid_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;

    // AXI4-Lite read path
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_r <= 1'b0;
            rdata_r <= '0;
            rresp_r <= TCM_RESP_OKAY;
        end
        else if (ce)
        begin
            if (s_axi_arvalid && !rvalid_r)
            begin
                rvalid_r <= 1'b1;
                rresp_r <= TCM_RESP_OKAY;
                unique case (s_axi_araddr)
                    TCM_OFS_CTRL: rdata_r <= ctrl_r;
                    TCM_OFS_STAT: rdata_r <= {26'h000_0000, crst_r, latch_r.rst_en,
                        latch_r.ratio_4x, mode_r};
                    TCM_OFS_SEL: rdata_r <= {26'h000_0000, latch_r.gp_sel, latch_r.sys_sel};
                    default:
                    begin
                        rdata_r <= '0;
                        rresp_r <= TCM_RESP_SLVERR;
                    end
                endcase
            end
            else if (rvalid_r && s_axi_rready)
                rvalid_r <= 1'b0;
        end
    end

    assign s_axi_arready = !rvalid_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

    property p_bypass_entry;
        @(posedge aclk) disable iff (!aresetn)
        (ce && !test_n && test_q_r && straps.ad[TCM_AD_BYPASS]) |=> mode_r == TCM_BYPASS;
    endproperty
    a_bypass_entry: assert property (p_bypass_entry) else $error("bypass not entered");

    property p_clkout_entry;
        @(posedge aclk) disable iff (!aresetn)
        (ce && !test_n && test_q_r && !straps.ad[TCM_AD_BYPASS] && !straps.par)
            |=> mode_r == TCM_CLKOUT;
    endproperty
    a_clkout_entry: assert property (p_clkout_entry) else $error("clock out not entered");

    property p_normal;
        @(posedge aclk) disable iff (!aresetn)
        (ce && test_n) |=> mode_r == TCM_NORMAL;
    endproperty
    a_normal: assert property (p_normal) else $error("test pin high not normal");

    property p_rst_en;
        @(posedge aclk) disable iff (!aresetn)
        (ce && !test_n && test_q_r) |=> latch_r.rst_en == !$past(straps.ad[TCM_AD_RSTEN]);
    endproperty
    a_rst_en: assert property (p_rst_en) else $error("reset enable strap wrong");

    property p_sync_rst;
        @(posedge aclk) disable iff (!aresetn)
        (ce && mode_r == TCM_BYPASS && latch_r.rst_en && !straps.irdy_n) |=> clk_logic_rst;
    endproperty
    a_sync_rst: assert property (p_sync_rst) else $error("clock reset missing");

    property p_no_rst;
        @(posedge aclk) disable iff (!aresetn)
        (ce && mode_r != TCM_BYPASS) |=> !clk_logic_rst;
    endproperty
    a_no_rst: assert property (p_no_rst) else $error("clock reset outside bypass");

    property p_gnt_bus;
        @(posedge aclk) disable iff (!aresetn)
        (ce && mode_r != TCM_CLKOUT) |=> gnt_n_out == $past(bus_gnt_n);
    endproperty
    a_gnt_bus: assert property (p_gnt_bus) else $error("grant not passed");

    property p_gnt_clk;
        @(posedge aclk) disable iff (!aresetn)
        (ce && mode_r == TCM_CLKOUT) |=> gnt_n_out == {$past(gp_obs), $past(sys_obs)};
    endproperty
    a_gnt_clk: assert property (p_gnt_clk) else $error("grant not clock");

    property p_sys_raw;
        @(posedge aclk) disable iff (!aresetn)
        (ce && latch_r.sys_sel == TCM_SEL_RAW) |=> sys_obs == $past(clocks.sys_clock_in);
    endproperty
    a_sys_raw: assert property (p_sys_raw) else $error("system raw select wrong");

    property p_gp_pll;
        @(posedge aclk) disable iff (!aresetn)
        (ce && latch_r.gp_sel == TCM_SEL_PLL) |=> gp_obs == $past(clocks.sys_pll_1x);
    endproperty
    a_gp_pll: assert property (p_gp_pll) else $error("graphics pll select wrong");

    property p_core_div;
        @(posedge aclk) disable iff (!aresetn)
        (ce && mode_r == TCM_BYPASS && ctrl_r[TCM_CTRL_CKEN]) |=> core_clk_en == $past(sys_div);
    endproperty
    a_core_div: assert property (p_core_div) else $error("core enable not divided");

    property p_gp_4x;
        @(posedge aclk) disable iff (!aresetn)
        (ce && mode_r == TCM_BYPASS && ctrl_r[TCM_CTRL_CKEN] && latch_r.ratio_4x)
            |=> gp_core_clk_en == ($past(clocks.graphics_port_clock_in) && !$past(gp_q_r));
    endproperty
    a_gp_4x: assert property (p_gp_4x) else $error("4x graphics enable wrong");
endmodule : tcm_test_clock

// ==== verif/tcm_board_model.sv ====
/* Board test equipment model: drives the test pin, the straps and the clocks.
 Assumes the bench clock; every change lands just after a rising edge. */
`timescale 1ns/1ps
module tcm_board_model (
    input wire logic aclk,
    output logic test_n,
    output tcm_pkg::tcm_straps_s straps,
    output tcm_pkg::tcm_clocks_s clocks
);
    import tcm_pkg::*;
    initial
    begin
        test_n = 1'b1;
        straps = '0;
        straps.irdy_n = 1'b1;
        clocks = '0;
    end
    task automatic set_clk(input logic s, input logic g, input logic p);
        @(posedge aclk);
        clocks <= '{s, g, p};
    endtask : set_clk
    task automatic irdy(input logic v);
        @(posedge aclk);
        straps.irdy_n <= v;
        repeat (3) @(posedge aclk);
    endtask : irdy
    // Straps set first and held through test pin entry
    task automatic enter(input logic lo, input logic byp, input logic par, input logic cbe1,
                         input logic ad29, input logic [2:0] ss, input logic [2:0] gs);
        logic [31:0] ad;
        ad = $urandom;
        ad[9] = byp;
        ad[29] = ad29;
        ad[7:5] = ss;
        ad[14:12] = gs;
        @(posedge aclk);
        test_n <= 1'b1;
        straps <= '{ad, {2'b11, cbe1, 1'b1}, par, 1'b1};
        repeat (2) @(posedge aclk);
        test_n <= ~lo;
        repeat (3) @(posedge aclk);
    endtask : enter
    // Slow test clock, two cycles high and two low
    task automatic pulses(input logic g, input int n);
        repeat (2 * n)
        begin
            @(posedge aclk);
            if (g)
                clocks.graphics_port_clock_in <= ~clocks.graphics_port_clock_in;
            else
                clocks.sys_clock_in <= ~clocks.sys_clock_in;
            @(posedge aclk);
        end
    endtask : pulses
endmodule : tcm_board_model

// ==== verif/testbench.sv ====
/* Self-checking bench: AXI4-Lite master, port probes and a board model.
 Assumes a 250 MHz clock and the design's registered outputs. */
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin error_cnt++; $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
    import tcm_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic ce = 1'b1;
    logic [6:5] bus_gnt_n = 2'b11;
    logic test_n;
    tcm_straps_s straps;
    tcm_clocks_s clocks;
    logic [6:5] gnt_n_out;
    logic core_clk_en, gp_core_clk_en, clk_logic_rst;
    tcm_mode_e mode_out;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    int error_cnt = 0;
    int checks_done = 0;
    int cyc = 0;
    int tgl = 0;
    int hi = 0;
    logic cnt_on = 0;
    logic prev = 0;
    logic [33:0] gv, ev;
    logic [33:0] rq[$], pq[$];
    logic [2:0] ps[$];
    logic [1:0] bq[$];
    logic [2:0] codes[4] = '{3'h1, 3'h4, 3'h2, 3'h0};
    logic [1:0] gexp[4] = '{2'b01, 2'b11, 2'b00, 2'b00};
    tcm_board_model board (.aclk, .test_n, .straps, .clocks);
    tcm_test_clock DUT (.aclk, .aresetn, .ce, .test_n, .straps, .clocks, .bus_gnt_n, .gnt_n_out,
        .core_clk_en, .gp_core_clk_en, .clk_logic_rst, .mode_out, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    always #2 aclk = ~aclk;
    function automatic logic [33:0] pick(input logic [2:0] s);
        case (s)
            3'h0: pick = {32'h0, gnt_n_out};
            3'h1: pick = {31'h0, mode_out};
            3'h2: pick = {33'h0, core_clk_en};
            3'h3: pick = {33'h0, clk_logic_rst};
            3'h4: pick = {2'h0, 32'(tgl)};
            default: pick = {2'h0, 32'(hi)};
        endcase
    endfunction : pick
    task automatic look(input logic [2:0] s, input logic [33:0] e);
        ps.push_back(s);
        pq.push_back(e);
    endtask : look
    // One AXI4-Lite transfer, expected response noted first
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                       input logic [33:0] e);
        logic ta, tw, tr, tb, done;
        if (wr)
            bq.push_back(e[33:32]);
        else
            rq.push_back(e);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= wr;
        s_axi_wvalid <= wr;
        s_axi_bready <= wr;
        s_axi_arvalid <= ~wr;
        s_axi_rready <= ~wr;
        do
        begin
            @(negedge aclk);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            tr = s_axi_arvalid && s_axi_arready;
            tb = wr ? (s_axi_bvalid && s_axi_bready) : (s_axi_rvalid && s_axi_rready);
            done = tb;
            @(posedge aclk);
            if (ta)
                s_axi_awvalid <= 1'b0;
            if (tw)
                s_axi_wvalid <= 1'b0;
            if (tr)
                s_axi_arvalid <= 1'b0;
            if (tb)
            begin
                s_axi_bready <= 1'b0;
                s_axi_rready <= 1'b0;
            end
        end while (!done);
    endtask : bus
    task automatic count(input logic g, input int n);
        @(posedge aclk);
        tgl = 0;
        hi = 0;
        prev = core_clk_en;
        cnt_on = 1'b1;
        board.pulses(g, n);
        repeat (6) @(posedge aclk);
        cnt_on = 1'b0;
    endtask : count
    // Result watcher: oldest note against what the outputs show
    always @(negedge aclk)
    begin
        if (cnt_on)
        begin
            hi += gp_core_clk_en;
            tgl += (core_clk_en != prev);
            prev = core_clk_en;
        end
        if (s_axi_rvalid && s_axi_rready)
        begin
            gv = {s_axi_rresp, s_axi_rdata};
            ev = rq.pop_front();
            `CHK(gv, ev)
        end
        if (s_axi_bvalid && s_axi_bready)
        begin
            gv = {32'h0, s_axi_bresp};
            ev = {32'h0, bq.pop_front()};
            `CHK(gv, ev)
        end
        while (ps.size() > 0)
        begin
            gv = pick(ps.pop_front());
            ev = pq.pop_front();
            `CHK(gv, ev)
        end
    end
    task automatic summarize();
        $display("mismatches %0d comparisons %0d", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : summarize
    always @(posedge aclk)
    begin
        cyc++;
        if (cyc == 6000)
        begin
            error_cnt++;
            summarize();
        end
    end
    initial
    begin
        void'($urandom(83));
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        bus(0, TCM_OFS_CTRL, 0, {TCM_RESP_OKAY, 32'h0000_0001});
        bus(0, 4'hC, 0, {TCM_RESP_SLVERR, 32'h0000_0000});
        bus(1, 4'hC, $urandom, {TCM_RESP_SLVERR, 32'h0000_0000});
        bus(1, TCM_OFS_STAT, 32'hFFFF_FFFF, {TCM_RESP_OKAY, 32'h0000_0000});
        bus(1, TCM_OFS_CTRL, 32'h0000_0000, {TCM_RESP_OKAY, 32'h0000_0000});
        bus(0, TCM_OFS_CTRL, 0, {TCM_RESP_OKAY, 32'h0000_0000});
        bus(1, TCM_OFS_CTRL, 32'h0000_0001, {TCM_RESP_OKAY, 32'h0000_0000});
        board.enter(1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 3'h0, 3'h0);
        look(1, TCM_NORMAL);
        for (int i = 0; i < 4; i++)
        begin
            @(posedge aclk);
            bus_gnt_n <= 2'($urandom);
            repeat (2) @(posedge aclk);
            look(0, {32'h0, bus_gnt_n});
            look(2, 1);
        end
        // Clock enable low freezes the grant register
        @(posedge aclk);
        ce <= 1'b0;
        bus_gnt_n <= ~bus_gnt_n;
        repeat (2) @(posedge aclk);
        look(0, {32'h0, ~bus_gnt_n});
        ce <= 1'b1;
        board.enter(1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 3'h1, 3'h1);
        look(1, TCM_NORMAL);
        board.set_clk(1'b1, 1'b0, 1'b1);
        for (int i = 0; i < 4; i++)
        begin
            board.enter(1'b1, 1'b0, 1'b0, 1'b1, 1'b1, codes[i], codes[i]);
            look(1, TCM_CLKOUT);
            bus(0, TCM_OFS_SEL, 0, {TCM_RESP_OKAY, 26'h0, codes[i], codes[i]});
            if (codes[i] != TCM_SEL_DIV2)
                look(0, {32'h0, gexp[i]});
        end
        board.set_clk(1'b0, 1'b0, 1'b0);
        board.enter(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 3'h0, 3'h0);
        look(1, TCM_BYPASS);
        bus(0, TCM_OFS_STAT, 0, {TCM_RESP_OKAY, 32'h0000_0012});
        count(1'b0, 4);
        look(4, 4);
        board.irdy(1'b0);
        look(3, 1);
        bus(0, TCM_OFS_STAT, 0, {TCM_RESP_OKAY, 32'h0000_0032});
        board.irdy(1'b1);
        look(3, 0);
        board.enter(1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 3'h0, 3'h0);
        bus(0, TCM_OFS_STAT, 0, {TCM_RESP_OKAY, 32'h0000_000A});
        count(1'b1, 3);
        look(5, 3);
        board.irdy(1'b0);
        look(3, 0);
        board.enter(1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 3'h0, 3'h0);
        look(1, TCM_NORMAL);
        look(2, 1);
        repeat (3) @(negedge aclk);
        summarize();
    end
endmodule : testbench
